// ==== test/sabt_bus_node.sv ====
// Wired-AND model of the shared serial line and a second node.
`timescale 1ns/1ns
module sabt_bus_node (
  input wire tx_pin_i,
  input wire dom_i,
  output wire rx_line_o
);
  // The line has a pull-up, so it is low only while a node drives it low.
  assign rx_line_o = tx_pin_i & ~dom_i;
endmodule

// ==== test/sabt_timer_monitor.sv ====
// Port checker of the arbiter bit timer.
`timescale 1ns/1ns
module sabt_timer_monitor (
  input wire core_clk_i,
  input wire rst_b_i,
  input wire [2:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire tx_serial_i,
  input wire tx_pin_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  reg [7:0] ctl_r;
  wire acc = !avs_waitrequest_o;
  wire rd_ok = acc && avs_read_i;
  wire ctl_rd = rd_ok && avs_address_i == 3'h0;
  wire dat_rd = rd_ok && avs_address_i == 3'h1;
  wire unm_rd = rd_ok && avs_address_i > 3'h4;
  wire idle = ctl_r[7:6] == 2'h0;
  // Keeps the last control byte accepted, to know the mode.
  always @(posedge core_clk_i) begin
    if (!rst_b_i)
      ctl_r <= 8'h00;
    else if (acc && avs_write_i && avs_address_i == 3'h0)
      ctl_r <= avs_writedata_i[7:0];
  end
  // A read is answered after one or two wait cycles.
  sequence answer_s;
    ##[1:2] !avs_waitrequest_o;
  endsequence
  wait_one_a: assert property (acc |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  answer_a: assert property ($rose(avs_read_i) |-> answer_s)
    else $error("read not answered in time");
  upper_a: assert property (avs_readdata_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  unmap_a: assert property (unm_rd |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  idle_cnt_a: assert property (idle && dat_rd |-> !avs_readdata_o)
    else $error("counter not zero in idle");
  idle_flag_a: assert property (idle && ctl_rd |->
    (avs_readdata_o & 32'h2f) == 32'h0)
    else $error("status bits set in idle");
  echo_a: assert property (ctl_rd |->
    avs_readdata_o[7:6] == ctl_r[7:6] && avs_readdata_o[4] == ctl_r[4])
    else $error("mode or clock bit not as written");
  tx_pass_a: assert property ($past(tx_serial_i) |-> tx_pin_o)
    else $error("transmit pin low while transmit high");
  tx_idle_a: assert property (idle && $past(idle) &&
    !$past(tx_serial_i) |-> !tx_pin_o)
    else $error("transmit pin forced high in idle");
endmodule

// ==== test/sabt_timer_tb.sv ====
// Self-checking bench of the arbiter bit timer.
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  err_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
module sabt_timer_tb;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg [2:0] adr = 3'h0;
  reg rd = 1'b0;
  reg we = 1'b0;
  reg [31:0] wd = 32'h0;
  reg tx = 1'b1;
  reg dom = 1'b0;
  reg xt = 1'b0;
  reg [7:0] d;
  integer err_count = 0;
  integer total_checks = 0;
  wire [31:0] rdat;
  wire wq, rx, txp, irq;
  sabt_timer sabt_timer_i (.core_clk_i(clk), .rst_b_i(rst_b),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(we),
    .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wq),
    .rx_line_i(rx), .tx_serial_i(tx), .xtal_clk_i(xt), .tx_pin_o(txp),
    .irq_o(irq));
  sabt_bus_node sabt_bus_node_i (.tx_pin_i(txp), .dom_i(dom),
    .rx_line_o(rx));
  // Waits a number of clock edges.
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // One bus write, held until waitrequest is seen low; mode writes never
  // use the reserved encoding.
  task wr(input [2:0] a, input [7:0] v);
    begin
      adr <= a;
      wd <= {24'h0, v};
      we <= 1'b1;
      @(posedge clk);
      while (wq) @(posedge clk);
      we <= 1'b0;
      @(posedge clk);
    end
  endtask
  // One bus read; data is taken at the accepting edge.
  task rg(input [2:0] a);
    begin
      adr <= a;
      rd <= 1'b1;
      @(posedge clk);
      while (wq) @(posedge clk);
      d = rdat[7:0];
      rd <= 1'b0;
      @(posedge clk);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial forever #20 clk = ~clk;
  // Free-running crystal stand-in at half the bench clock rate.
  always @(posedge clk) xt <= ~xt;
  // Cuts a hang short.
  initial begin
    cyc(20000);
    err_count++;
    give_verdict;
  end
  // Main sequence of tests.
  initial begin
    cyc(16);
    rst_b <= 1'b1;
    rg(0); `CHK("ctl", 8'h00, d)
    rg(7); `CHK("unmapped", 8'h00, d)
    wr(0, 8'h2f);
    rg(0); `CHK("ctl ro", 8'h00, d)
    $display("reset test done");
    wr(0, 8'h40);
    dom <= 1'b1;
    cyc(400);
    rg(0); `CHK("running", 8'h42, d)
    dom <= 1'b0;
    cyc(20);
    dom <= 1'b1;
    cyc(10);
    dom <= 1'b0;
    cyc(10);
    rg(0); `CHK("done", 8'h41, d)
    rg(1); `CHK("count", 1'b1, d >= 8'd103 && d <= 8'd108)
    rg(3); `CHK("istat", 8'h01, d)
    `CHK("irq masked", 1'b0, irq)
    wr(4, 8'h07);
    cyc(2); `CHK("irq", 1'b1, irq)
    wr(3, 8'h01);
    cyc(2); `CHK("irq clr", 1'b0, irq)
    wr(0, 8'h40);
    rg(0); `CHK("ctl clr", 8'h40, d)
    rg(1); `CHK("cnt clr", 8'h00, d)
    $display("edge measure test done");
    dom <= 1'b1;
    wr(0, 8'h50);
    cyc(600);
    rg(0); `CHK("brk run", 8'h5a, d)
    dom <= 1'b0;
    cyc(10);
    rg(0); `CHK("brk done", 8'h59, d)
    wr(0, 8'h40);
    dom <= 1'b1;
    cyc(10);
    dom <= 1'b0;
    cyc(2100);
    dom <= 1'b1;
    cyc(10);
    rg(0); `CHK("ovf", 8'h45, d)
    rg(3); `CHK("istat ovf", 8'h03, d)
    rst_b <= 1'b0;
    cyc(2);
    rst_b <= 1'b1;
    rg(0); `CHK("ctl rst", 8'h00, d)
    rg(3); `CHK("istat rst", 8'h00, d)
    `CHK("irq rst", 1'b0, irq)
    wr(4, 8'h07);
    wr(3, 8'h07);
    dom <= 1'b0;
    wr(0, 8'h00);
    rg(0); `CHK("idle", 8'h00, d)
    $display("level measure test done");
    tx <= 1'b0;
    dom <= 1'b1;
    wr(0, 8'h80);
    tx <= 1'b1;
    cyc(300);
    rg(0); `CHK("lost", 8'ha0, d & 8'he0)
    rg(3); `CHK("istat lost", 8'h04, d)
    `CHK("irq lost", 1'b1, irq)
    tx <= 1'b0;
    cyc(3); `CHK("tx forced", 1'b1, txp)
    wr(0, 8'h00);
    rg(0); `CHK("lost clr", 8'h00, d)
    $display("arbitration test done");
    tx <= 1'b1;
    dom <= 1'b0;
    wr(2, 8'h03);
    rg(2); `CHK("cfg", 8'h03, d)
    wr(0, 8'h50);
    dom <= 1'b1;
    cyc(400);
    dom <= 1'b0;
    cyc(10);
    rg(0); `CHK("xtal done", 8'h51, d)
    rg(1); `CHK("xtal count", 1'b1, d >= 8'd48 && d <= 8'd51)
    $display("crystal prescaler test done");
    give_verdict;
  end
endmodule
bind sabt_timer sabt_timer_monitor sabt_timer_monitor_i (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .tx_serial_i(tx_serial_i),
  .tx_pin_o(tx_pin_o));

// ==== verilog/sabt_map.vh ====
// Register map, field positions and timing counts of the arbiter bit timer.
`ifndef SABT_MAP_VH
`define SABT_MAP_VH
`define SABT_ADDR_CTL 3'h0
`define SABT_ADDR_DAT 3'h1
`define SABT_ADDR_CFG 3'h2
`define SABT_ADDR_IST 3'h3
`define SABT_ADDR_IMSK 3'h4
`define SABT_CTL_DONE 0
`define SABT_CTL_RUN 1
`define SABT_CTL_OVF 2
`define SABT_CTL_MSB 3
`define SABT_CTL_ACLK 4
`define SABT_CTL_LOST 5
`define SABT_CTL_MLO 6
`define SABT_CTL_MHI 7
`define SABT_MODE_IDLE 2'h0
`define SABT_MODE_MEAS 2'h1
`define SABT_MODE_ARB 2'h2
`define SABT_SAMPLE_BUS 9'h038
`define SABT_SAMPLE_PRE 9'h008
`define SABT_BUS_DIV 2'h3
`define SABT_CFG_RESET 8'h00
`endif

// ==== verilog/sabt_timer.v ====
// Arbiter bit timer with an Avalon-MM register slave and interrupt.
`timescale 1ns/1ns
`include "sabt_map.vh"

// How it works
// - Nine-bit counter plus separate overflow bit.
// - Mode field selects idle, measure, arbitrate, reserved.
// - Reset clears both mode bits to idle.
// - Lost flag cleared by zero upper mode bit.
// - Clock select picks half prescaler or bus/4.
// - Prescaler source is bus or crystal clock.
// - Done flag set at end, write clears.
// - Running flag shows counter activity.
// - Overflow flag set on wrap, write clears.
// - Mode zero resets and holds the counter.
// - Counter top bit readable, write clears.
// - Bus-clock measure runs falling edge to falling.
// - Prescaler measure runs low level to rising.
// - Arbitration samples receive line, loses, forces high.
// - Low counter byte readable, control write clears.
module sabt_timer (
  input wire core_clk_i,
  input wire rst_b_i,
  input wire [2:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  input wire rx_line_i,
  input wire tx_serial_i,
  input wire xtal_clk_i,
  output reg tx_pin_o,
  output reg irq_o
);

  // One-hot counter states: idle waits for a start condition, wait
  // parks the arbitration counter until the next transmit rise, and
  // run counts ticks.
  localparam ST_IDLE = 3'h1;
  localparam ST_WAIT = 3'h2;
  localparam ST_RUN = 3'h4;

  // Two-flop synchronisers for the receive line and the crystal clock,
  // each followed by one delay flop for edge detection.
  reg [1:0] rx_sync_r;
  reg [1:0] xt_sync_r;
  reg rx_d_r;
  reg xt_d_r;
  reg tx_d_r;
  // Control fields and the flags that hardware sets.
  reg [1:0] mode_r;
  reg aclk_r;
  reg lost_r;
  reg done_r;
  reg ovf_r;
  // Nine-bit bit-time counter; its carry sets the overflow flag.
  reg [8:0] cnt_r;
  reg [2:0] st_r;
  // Configuration byte: prescaler source and divisor.
  reg [7:0] cfg_r;
  reg [1:0] bus_div_r;
  reg [7:0] pre_cnt_r;
  reg pre_half_r;
  reg sampled_r;
  // Interrupt status and mask, and the accept phase of the bus.
  reg [3:0] ist_r;
  reg [3:0] imsk_r;
  reg ack_r;

  // Edge detectors work on the synchronised receive line and crystal clock and on the raw transmit input. The
  // delay flops reset to the idle level of each input, so leaving
  // reset never looks like an edge.
  wire rx_s = rx_sync_r[1];
  wire rx_fall = rx_d_r & ~rx_s;
  wire rx_rise = ~rx_d_r & rx_s;
  wire tx_rise = tx_serial_i & ~tx_d_r;
  wire xt_rise = xt_sync_r[1] & ~xt_d_r;
  // Prescaler source: bus clock tick or crystal edge, config bit 0.
  wire pre_src = cfg_r[0] ? xt_rise : 1'b1;
  // Prescaler divisor is config bits 7:1 plus one.
  wire pre_out = pre_src & (pre_cnt_r == {1'b0, cfg_r[7:1]});
  // Counter tick: bus/4 or half the prescaler output.
  wire tick = aclk_r ? (pre_out & pre_half_r) : (bus_div_r == `SABT_BUS_DIV);
  // A write takes effect only in the accept cycle, when ack_r is high,
  // so a request held over the wait cycle is applied exactly once.
  wire ctl_wr = avs_write_i & ack_r & (avs_address_i == `SABT_ADDR_CTL);
  wire ist_wr = avs_write_i & ack_r & (avs_address_i == `SABT_ADDR_IST);
  wire running = (st_r == ST_RUN);
  wire [8:0] smp = aclk_r ? `SABT_SAMPLE_PRE : `SABT_SAMPLE_BUS;
  wire [9:0] cnt_inc = {1'b0, cnt_r} + 10'h001;
  // Overflow is the carry out of the nine-bit counter on a tick.
  wire wrap = running & tick & cnt_inc[9];
  // A measurement ends on the edge that matches its clock: falling for
  // the bus clock, rising for the prescaler clock.
  wire fin_meas = (mode_r == `SABT_MODE_MEAS) & running &
                  (aclk_r ? rx_rise : rx_fall);
  // The receive line is sampled once per transmit rise, on the tick at
  // which the counter stands at its sample point.
  wire lose = (mode_r == `SABT_MODE_ARB) & running & tick &
              ~sampled_r & (cnt_r == smp) & ~rx_s;
  // Control byte as software reads it.
  wire [7:0] ctl_val = {mode_r, lost_r, aclk_r, cnt_r[8], ovf_r,
                        running, done_r};
  // Read data for the current address, registered in the bus block.
  reg [7:0] rd_nxt;

  // Synchronise the receive line and the crystal clock.
  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      rx_sync_r <= 2'h3;
      xt_sync_r <= 2'h0;
      rx_d_r <= 1'b1;
      xt_d_r <= 1'b0;
      tx_d_r <= 1'b1; // Transmit idles high, so no edge follows reset.
    end else begin
      rx_sync_r <= {rx_sync_r[0], rx_line_i};
      xt_sync_r <= {xt_sync_r[0], xtal_clk_i};
      rx_d_r <= rx_s;
      xt_d_r <= xt_sync_r[1];
      tx_d_r <= tx_serial_i;
    end
  end

  // Clock dividers feeding the counter tick; the baud generator is
  // elsewhere, this only derives the arbiter rate.
  // The prescaler counts source pulses up to the configured divisor;
  // its half-rate flip gates the counter tick.
  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      bus_div_r <= 2'h0;
      pre_cnt_r <= 8'h00;
      pre_half_r <= 1'b0;
    end else begin
      bus_div_r <= bus_div_r + 2'h1;
      if (pre_out) begin
        pre_cnt_r <= 8'h00;
        pre_half_r <= ~pre_half_r;
      end else if (pre_src) begin
        pre_cnt_r <= pre_cnt_r + 8'h01;
      end
    end
  end

  // Control register fields and the lost flag.
  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      mode_r <= `SABT_MODE_IDLE;
      aclk_r <= 1'b0;
      lost_r <= 1'b0;
      cfg_r <= `SABT_CFG_RESET;
    end else begin
      // Mode and clock select are the only writable control bits.
      if (ctl_wr) begin
        mode_r <= avs_writedata_i[`SABT_CTL_MHI:`SABT_CTL_MLO];
        aclk_r <= avs_writedata_i[`SABT_CTL_ACLK];
      end
      if (avs_write_i & ack_r & (avs_address_i == `SABT_ADDR_CFG))
        cfg_r <= avs_writedata_i[7:0];
      // Setting wins over a clearing write in the same cycle.
      if (lose)
        lost_r <= 1'b1;
      else if (ctl_wr & ~avs_writedata_i[`SABT_CTL_MHI])
        lost_r <= 1'b0;
    end
  end

  // Counter state machine for measurement and arbitration.
  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      st_r <= ST_IDLE;
      cnt_r <= 9'h000;
      ovf_r <= 1'b0;
      done_r <= 1'b0;
      sampled_r <= 1'b0;
    end else begin
      // Control writes clear the flags, but hardware events win.
      if (fin_meas)
        done_r <= 1'b1;
      else if (ctl_wr)
        done_r <= 1'b0;
      if (wrap)
        ovf_r <= 1'b1;
      else if (ctl_wr)
        ovf_r <= 1'b0;
      // Any control write restarts the counter, so software always begins
      // from a clean count in the newly written mode.
      if (ctl_wr) begin
        cnt_r <= 9'h000;
        st_r <= ST_IDLE;
        sampled_r <= 1'b0;
      end else begin
        case (mode_r)
          // After a finished measurement the counter stays idle until the
          // next control write, so the result cannot be overwritten.
          `SABT_MODE_MEAS: begin
            case (st_r)
              ST_IDLE: begin
                if (done_r)
                  st_r <= ST_IDLE;
                else if (aclk_r ? ~rx_s : rx_fall)
                  st_r <= ST_RUN;
                else
                  st_r <= ST_IDLE;
              end
              ST_RUN: begin
                if (fin_meas)
                  st_r <= ST_IDLE;
                else if (tick)
                  cnt_r <= cnt_inc[8:0];
              end
              default: st_r <= ST_IDLE;
            endcase
          end
          // Arbitration restarts on every transmit rise. A transmit low
          // before the sample point parks the counter until the next rise.
          `SABT_MODE_ARB: begin
            if (tx_rise) begin
              cnt_r <= 9'h000;
              st_r <= ST_RUN;
              sampled_r <= 1'b0;
            end else if (running & ~tx_serial_i & ~sampled_r) begin
              cnt_r <= 9'h000;
              st_r <= ST_WAIT;
            end else if (running & tick) begin
              cnt_r <= cnt_inc[8:0];
              if (cnt_r == smp)
                sampled_r <= 1'b1;
            end
          end
          // Idle and the reserved code hold the counter cleared.
          default: begin
            cnt_r <= 9'h000;
            st_r <= ST_IDLE;
            sampled_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // Transmit pin is forced high while arbitration is lost.
  // The pin is registered; lose is ORed in beside the flag so that the
  // first forced cycle is not one clock late.
  always @(posedge core_clk_i) begin
    if (!rst_b_i)
      tx_pin_o <= 1'b1;
    else
      tx_pin_o <= tx_serial_i | lost_r | lose;
  end

  // Sticky interrupt status: done, overflow, lost; write one to clear.
  // Bit 3 is spare and reads zero; a set wins over a clearing write.
  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      ist_r <= 4'h0;
      imsk_r <= 4'h0;
      irq_o <= 1'b0;
    end else begin
      ist_r <= ({1'b0, lose, wrap, fin_meas}) |
               (ist_r & ~(ist_wr ? avs_writedata_i[3:0] : 4'h0));
      if (avs_write_i & ack_r & (avs_address_i == `SABT_ADDR_IMSK))
        imsk_r <= avs_writedata_i[3:0];
      irq_o <= |(ist_r & imsk_r);
    end
  end

  // Read data selection.
  // Unmapped addresses read zero.
  always @* begin
    rd_nxt = 8'h00;
    if (avs_address_i == `SABT_ADDR_CTL)
      rd_nxt = ctl_val;
    else if (avs_address_i == `SABT_ADDR_DAT)
      rd_nxt = cnt_r[7:0];
    else if (avs_address_i == `SABT_ADDR_CFG)
      rd_nxt = cfg_r;
    else if (avs_address_i == `SABT_ADDR_IST)
      rd_nxt = {4'h0, ist_r};
    else if (avs_address_i == `SABT_ADDR_IMSK)
      rd_nxt = {4'h0, imsk_r};
    else
      rd_nxt = 8'h00;
  end

  // Avalon slave: one wait cycle, then accept for one cycle.
  // Read data is captured in the wait cycle and stands at the edge where
  // waitrequest is low, which is when the master takes it.
  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      ack_r <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h00000000;
    end else begin
      ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & ~ack_r);
      if (avs_read_i & ~ack_r)
        avs_readdata_o <= {24'h000000, rd_nxt};
    end
  end

endmodule
